// [hdl/link_serializer.sv]
// Master serializer: five symbols per pixel word, then one idle symbol.
`timescale 1ns/10ps
`include "rgb_link_defines.svh"
module link_serializer
   import rgb_link_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   pix_word_if.ser         wi,
   output logic [3:0]      sym_out
);
   ser_state_t  state_ff, nxt_state;
   logic [2:0]  cnt_ff, nxt_cnt;
   logic [15:0] sh_ff, nxt_sh;
   logic [3:0]  sym_ff, nxt_sym;
   logic        pend_ff, nxt_pend;
   logic [17:0] pend_word_ff, nxt_pend_word;
   logic [17:0] src;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_sh        = sh_ff;
      nxt_sym       = `IDLE_SYM;
      nxt_pend      = pend_ff;
      nxt_pend_word = pend_word_ff;
      src           = pend_ff ? pend_word_ff : wi.word;
      case (state_ff)
         SER_IDLE: begin
            if (pend_ff || wi.load) begin
               // first symbol carries start code and syncs
               nxt_sym   = {`START_CODE, src[`FS_BIT], src[`LS_BIT]};
               nxt_sh    = src[15:0];
               nxt_cnt   = `SYMS_PER_WORD - 3'd1;
               nxt_state = SER_SEND;
               nxt_pend  = pend_ff && wi.load;
               if (pend_ff && wi.load) begin
                  nxt_pend_word = wi.word;
               end
            end
         end
         SER_SEND: begin
            nxt_sym = sh_ff[15:12];
            nxt_sh  = {sh_ff[11:0], 4'h0};
            nxt_cnt = cnt_ff - 3'd1;
            if (cnt_ff == 3'd1) begin
               nxt_state = SER_GAP;
            end
         end
         SER_GAP: begin
            // one idle symbol before the next word
            nxt_state = SER_IDLE;
         end
         default: begin
            nxt_state = SER_IDLE;
         end
      endcase
      if (state_ff != SER_IDLE && wi.load) begin
         nxt_pend      = 1'b1;
         nxt_pend_word = wi.word;
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff     <= SER_IDLE;
         cnt_ff       <= 3'h0;
         sh_ff        <= 16'h0000;
         sym_ff       <= `IDLE_SYM;
         pend_ff      <= 1'b0;
         pend_word_ff <= 18'h00000;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         sh_ff        <= nxt_sh;
         sym_ff       <= nxt_sym;
         pend_ff      <= nxt_pend;
         pend_word_ff <= nxt_pend_word;
      end
   end

   assign sym_out = sym_ff;
   assign wi.busy = pend_ff;
endmodule

// [hdl/pix_word_if.sv]
// Carrier for captured pixel words from capture logic to serializer.
`timescale 1ns/10ps
interface pix_word_if;
   logic [17:0] word;
   logic        load;
   logic        busy;
   modport src (output word, output load, input busy);
   modport ser (input word, input load, output busy);
endinterface

// [hdl/rgb_link_defines.svh]
// Offsets, codes and cycle counts for the pixel serial transport.
`ifndef RGB_LINK_DEFINES_SVH
`define RGB_LINK_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define SYMS_PER_WORD    3'd5
`define IDLE_SYMS        3'd1
`define PIX_LOW_CYCLES   3'd3
`define PIX_HIGH_6X      3'd3
`define PIX_HIGH_8X      3'd5
`define PIX_MIN_KHZ      3000
`define PIX_MAX_KHZ      12800

// ----------------------------------------------------------------------
// Link symbol layout
// ----------------------------------------------------------------------
`define START_CODE       2'h2
`define IDLE_SYM         4'h0
`define SYM_W            4
`define WORD_W           18
`define FS_BIT           17
`define LS_BIT           16

// ----------------------------------------------------------------------
// Multiplier select codes
// ----------------------------------------------------------------------
`define MULT_2X          3'h0
`define MULT_6X          3'h2
`define MULT_8X          3'h3

`endif

// [hdl/rgb_link_pkg.sv]
// Types shared by the pixel serial transport modules.
package rgb_link_pkg;
   typedef enum {SER_IDLE, SER_SEND, SER_GAP} ser_state_t;
   typedef enum {RX_HUNT, RX_DATA} rx_state_t;
   typedef enum {PC_HIGH_IDLE, PC_LOW, PC_HIGH} pclk_state_t;
endpackage

// [hdl/rgb_link_top.sv]
// Pixel bus transport: master capture and serializer, slave deserializer.
// ----------------------------------------------------------------------
// Overview of operation
// - Link carries 16 colour bits 5-6-5, pixel clock and two syncs.
// - Master sends one pixel word with syncs and overhead in five link cycles.
// - Slave pixel clock is low three link cycles, then high two plus idle.
// - The 8X multiplier still works with 37.5% pixel clock duty.
// - At 6X the pixel clock may run from 3 to 12.8 MHz.
// - Master captures colour and syncs on each rising strobe edge.
// - One idle link cycle follows each five-cycle word.
// - Slave outputs word and syncs; pixel clock trails data by one cycle.
// - Link clock is reference frequency times the selected multiplier.
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`include "rgb_link_defines.svh"
module rgb_link_top
   import rgb_link_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        PIX_STROBE,
   input  wire logic [15:0] PIX_COLOUR,
   input  wire logic        LINE_SYNC,
   input  wire logic        FRAME_SYNC,
   input  wire logic [2:0]  PLL_MULT_SEL,
   output logic      [3:0]  LINK_DATA_OUT,
   input  wire logic [3:0]  LINK_DATA_IN,
   output logic      [15:0] OUT_COLOUR,
   output logic             OUT_LINE_SYNC,
   output logic             OUT_FRAME_SYNC,
   output logic             OUT_PIX_CLK,
   output logic             CAPTURE_BUSY
);
   // Only a two-flop synchroniser is built, so any other depth is refused.
   if (SYNC_STAGES != 2) begin
      $error("SYNC_STAGES must be 2");
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [18:0] in_s1_ff, in_s2_ff;
   logic [2:0]  mult_s1_ff, mult_s2_ff;
   logic [3:0]  rx_s1_ff, rx_s2_ff;
   logic        strobe_d_ff;

   always_ff @(posedge CLK) begin
      if (RST) begin
         // The strobe idles high, so a parked strobe at release is no new word.
         in_s1_ff    <= 19'h40000;
         in_s2_ff    <= 19'h40000;
         mult_s1_ff  <= `MULT_6X;
         mult_s2_ff  <= `MULT_6X;
         rx_s1_ff    <= `IDLE_SYM;
         rx_s2_ff    <= `IDLE_SYM;
         strobe_d_ff <= 1'b1;
      end else begin
         in_s1_ff    <= {PIX_STROBE, FRAME_SYNC, LINE_SYNC, PIX_COLOUR};
         in_s2_ff    <= in_s1_ff;
         mult_s1_ff  <= PLL_MULT_SEL;
         mult_s2_ff  <= mult_s1_ff;
         rx_s1_ff    <= LINK_DATA_IN;
         rx_s2_ff    <= rx_s1_ff;
         strobe_d_ff <= in_s2_ff[18];
      end
   end

   // ----------------------------------------------------------------------
   // Master capture
   // ----------------------------------------------------------------------
   pix_word_if wi ();
   logic        load_ff, nxt_load;
   logic [17:0] word_ff, nxt_word;
   logic        busy_ff;

   always_comb begin
      nxt_word = word_ff;
      nxt_load = in_s2_ff[18] && !strobe_d_ff;
      if (nxt_load) begin
         nxt_word = in_s2_ff[17:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         load_ff <= 1'b0;
         word_ff <= 18'h00000;
         busy_ff <= 1'b0;
      end else begin
         load_ff <= nxt_load;
         word_ff <= nxt_word;
         busy_ff <= wi.busy;
      end
   end

   assign wi.load      = load_ff;
   assign wi.word      = word_ff;
   assign CAPTURE_BUSY = busy_ff;

   link_serializer u_ser (
      .clk     (CLK),
      .rst     (RST),
      .wi      (wi.ser),
      .sym_out (LINK_DATA_OUT)
   );

   // ----------------------------------------------------------------------
   // Slave deserializer
   // ----------------------------------------------------------------------
   rx_state_t   rx_state_ff, nxt_rx_state;
   logic [2:0]  rx_cnt_ff, nxt_rx_cnt;
   logic [11:0] rx_sh_ff, nxt_rx_sh;
   logic [1:0]  rx_sync_ff, nxt_rx_sync;
   logic [15:0] colour_ff, nxt_colour;
   logic        ls_ff, nxt_ls;
   logic        fs_ff, nxt_fs;
   logic        done_ff, nxt_done;

   always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_cnt   = rx_cnt_ff;
      nxt_rx_sh    = rx_sh_ff;
      nxt_rx_sync  = rx_sync_ff;
      nxt_colour   = colour_ff;
      nxt_ls       = ls_ff;
      nxt_fs       = fs_ff;
      nxt_done     = 1'b0;
      case (rx_state_ff)
         RX_HUNT: begin
            if (rx_s2_ff[3:2] == `START_CODE) begin
               nxt_rx_sync  = rx_s2_ff[1:0];
               nxt_rx_cnt   = `SYMS_PER_WORD - 3'd1;
               nxt_rx_state = RX_DATA;
            end
         end
         RX_DATA: begin
            nxt_rx_sh  = {rx_sh_ff[7:0], rx_s2_ff};
            nxt_rx_cnt = rx_cnt_ff - 3'd1;
            if (rx_cnt_ff == 3'd1) begin
               // syncs leave with their own colour word
               nxt_colour   = {rx_sh_ff, rx_s2_ff};
               nxt_fs       = rx_sync_ff[1];
               nxt_ls       = rx_sync_ff[0];
               nxt_done     = 1'b1;
               nxt_rx_state = RX_HUNT;
            end
         end
         default: begin
            nxt_rx_state = RX_HUNT;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_state_ff <= RX_HUNT;
         rx_cnt_ff   <= 3'h0;
         rx_sh_ff    <= 12'h000;
         rx_sync_ff  <= 2'h0;
         colour_ff   <= 16'h0000;
         ls_ff       <= 1'b0;
         fs_ff       <= 1'b0;
         done_ff     <= 1'b0;
      end else begin
         rx_state_ff <= nxt_rx_state;
         rx_cnt_ff   <= nxt_rx_cnt;
         rx_sh_ff    <= nxt_rx_sh;
         rx_sync_ff  <= nxt_rx_sync;
         colour_ff   <= nxt_colour;
         ls_ff       <= nxt_ls;
         fs_ff       <= nxt_fs;
         done_ff     <= nxt_done;
      end
   end

   assign OUT_COLOUR     = colour_ff;
   assign OUT_LINE_SYNC  = ls_ff;
   assign OUT_FRAME_SYNC = fs_ff;

   // ----------------------------------------------------------------------
   // Regenerated pixel clock
   // ----------------------------------------------------------------------
   // High time depends on the multiplier; 8X stretches it, so duty drops.
   function automatic logic [2:0] high_cycles(input logic [2:0] sel);
      high_cycles = (sel == `MULT_8X) ? `PIX_HIGH_8X : `PIX_HIGH_6X;
   endfunction

   pclk_state_t pc_state_ff, nxt_pc_state;
   logic [2:0]  pc_cnt_ff, nxt_pc_cnt;
   logic        pclk_ff, nxt_pclk;

   always_comb begin
      nxt_pc_state = pc_state_ff;
      nxt_pc_cnt   = pc_cnt_ff;
      nxt_pclk     = pclk_ff;
      case (pc_state_ff)
         PC_HIGH_IDLE: begin
            nxt_pclk = 1'b1;
         end
         PC_LOW: begin
            nxt_pc_cnt = pc_cnt_ff - 3'd1;
            if (pc_cnt_ff == 3'd1) begin
               // high time from multiplier, 5 at 8X
               nxt_pclk     = 1'b1;
               nxt_pc_cnt   = high_cycles(mult_s2_ff);
               nxt_pc_state = PC_HIGH;
            end
         end
         PC_HIGH: begin
            nxt_pc_cnt = pc_cnt_ff - 3'd1;
            if (pc_cnt_ff == 3'd1) begin
               nxt_pc_state = PC_HIGH_IDLE;
            end
         end
         default: begin
            nxt_pc_state = PC_HIGH_IDLE;
         end
      endcase
      // A new word restarts the low phase so no pixel edge is lost.
      if (done_ff) begin
         nxt_pclk     = 1'b0;
         nxt_pc_cnt   = `PIX_LOW_CYCLES;
         nxt_pc_state = PC_LOW;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pc_state_ff <= PC_HIGH_IDLE;
         pc_cnt_ff   <= 3'h0;
         pclk_ff     <= 1'b1;
      end else begin
         pc_state_ff <= nxt_pc_state;
         pc_cnt_ff   <= nxt_pc_cnt;
         pclk_ff     <= nxt_pclk;
      end
   end

   // falls one cycle after the data changes
   assign OUT_PIX_CLK = pclk_ff;
endmodule

// [testbench/pix_source.sv]
// Pixel source model driving the strobe, colour word and syncs.
`timescale 1ns/10ps
module pix_source (
   input  wire logic        clk,
   output logic             strobe,
   output logic      [15:0] colour,
   output logic             line_sync,
   output logic             frame_sync
);
   // The write strobe idles high, as an i80 style strobe does between writes.
   initial begin
      strobe = 1'b1;
      colour = 16'h0000;
      line_sync = 1'b0;
      frame_sync = 1'b0;
   end

   // pixel clock synchronous
   // Data changes with the falling strobe so it is stable around each rise.
   task automatic send(input logic [15:0] c, input logic ls, input logic fs, input int high);
      @(posedge clk);
      #1;
      strobe = 1'b0;
      colour = c;
      line_sync = ls;
      frame_sync = fs;
      repeat (3) @(posedge clk);
      #1;
      strobe = 1'b1;
      repeat (high - 1) @(posedge clk);
   endtask
endmodule

// [testbench/rgb_link_checker.sv]
// Concurrent checks on the ports of the pixel serial transport top module.
`timescale 1ns/10ps
`include "rgb_link_defines.svh"
module rgb_link_checker
   import rgb_link_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        PIX_STROBE,
   input wire logic [15:0] PIX_COLOUR,
   input wire logic        LINE_SYNC,
   input wire logic        FRAME_SYNC,
   input wire logic [2:0]  PLL_MULT_SEL,
   input wire logic [3:0]  LINK_DATA_OUT,
   input wire logic [3:0]  LINK_DATA_IN,
   input wire logic [15:0] OUT_COLOUR,
   input wire logic        OUT_LINE_SYNC,
   input wire logic        OUT_FRAME_SYNC,
   input wire logic        OUT_PIX_CLK,
   input wire logic        CAPTURE_BUSY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // ----------------------------------------------------------------
   // Link symbol sequences
   // ----------------------------------------------------------------
   sequence start_sym_s;
      LINK_DATA_OUT == {`START_CODE, $past(FRAME_SYNC, 5), $past(LINE_SYNC, 5)};
   endsequence
   sequence nibbles_s;
      LINK_DATA_OUT == $past(PIX_COLOUR[15:12], 6) ##1
      LINK_DATA_OUT == $past(PIX_COLOUR[11:8], 7) ##1
      LINK_DATA_OUT == $past(PIX_COLOUR[7:4], 8) ##1
      LINK_DATA_OUT == $past(PIX_COLOUR[3:0], 9);
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   // Two synchroniser flops, the load flop and the symbol flop: four edges deep.
   start_symbol_a: assert property (
      $rose(PIX_STROBE) |-> ##4 start_sym_s) else $error("start symbol wrong");
   colour_nibbles_a: assert property (
      $rose(PIX_STROBE) |-> ##5 nibbles_s) else $error("colour nibbles wrong");
   idle_gap_a: assert property (
      $rose(PIX_STROBE) |-> ##4 start_sym_s ##1 nibbles_s ##1 LINK_DATA_OUT == `IDLE_SYM)
      else $error("no idle symbol after word");
   reset_values_a: assert property (disable iff (1'b0) RST |=>
      LINK_DATA_OUT == 4'h0 && OUT_PIX_CLK && !CAPTURE_BUSY && OUT_COLOUR == 16'h0000)
      else $error("reset values wrong");
   pclk_low_a: assert property (
      $fell(OUT_PIX_CLK) |-> !OUT_PIX_CLK [*3] ##1 OUT_PIX_CLK) else $error("low phase wrong");
   pclk_high_a: assert property (
      $rose(OUT_PIX_CLK) && PLL_MULT_SEL != `MULT_8X |-> OUT_PIX_CLK [*3])
      else $error("high phase too short");
   pclk_wide_a: assert property (
      $rose(OUT_PIX_CLK) && PLL_MULT_SEL == `MULT_8X |-> OUT_PIX_CLK [*5])
      else $error("wide high phase too short");
   pclk_trails_a: assert property (
      $changed(OUT_COLOUR) |=> $fell(OUT_PIX_CLK)) else $error("clock not one cycle late");
   sync_aligned_a: assert property (
      $changed(OUT_LINE_SYNC) || $changed(OUT_FRAME_SYNC) |=> $fell(OUT_PIX_CLK))
      else $error("sync moved outside word update");
endmodule

bind rgb_link_top rgb_link_checker #(.SYNC_STAGES(SYNC_STAGES)) chk (
   .CLK(CLK), .RST(RST), .PIX_STROBE(PIX_STROBE), .PIX_COLOUR(PIX_COLOUR),
   .LINE_SYNC(LINE_SYNC), .FRAME_SYNC(FRAME_SYNC), .PLL_MULT_SEL(PLL_MULT_SEL),
   .LINK_DATA_OUT(LINK_DATA_OUT), .LINK_DATA_IN(LINK_DATA_IN), .OUT_COLOUR(OUT_COLOUR),
   .OUT_LINE_SYNC(OUT_LINE_SYNC), .OUT_FRAME_SYNC(OUT_FRAME_SYNC),
   .OUT_PIX_CLK(OUT_PIX_CLK), .CAPTURE_BUSY(CAPTURE_BUSY));

// [testbench/tb_rgb_link_top.sv]
// Self-checking testbench for the pixel serial transport with link loopback.
`timescale 1ns/10ps
`include "rgb_link_defines.svh"
module tb_rgb_link_top;
   logic        clk;
   logic        rst;
   logic        strobe;
   logic [15:0] colour;
   logic        ls;
   logic        fs;
   logic [2:0]  mult;
   logic [3:0]  link;
   logic [15:0] out_colour;
   logic        out_ls;
   logic        out_fs;
   logic        out_pclk;
   logic        busy;
   int          miscompares;
   int          samples_checked;
   logic [15:0] word_tab [3] = '{16'hf81f, 16'h07e0, 16'h001f};
   logic [1:0]  sync_tab [3] = '{2'h3, 2'h2, 2'h1};
   logic [2:0]  mode_tab [3] = '{`MULT_2X, `MULT_6X, `MULT_8X};

   always #5 clk = ~clk;

   // The master output feeds the slave input directly.
   rgb_link_top #(.SYNC_STAGES(2)) dut (
      .CLK(clk), .RST(rst), .PIX_STROBE(strobe), .PIX_COLOUR(colour), .LINE_SYNC(ls),
      .FRAME_SYNC(fs), .PLL_MULT_SEL(mult), .LINK_DATA_OUT(link), .LINK_DATA_IN(link),
      .OUT_COLOUR(out_colour), .OUT_LINE_SYNC(out_ls), .OUT_FRAME_SYNC(out_fs),
      .OUT_PIX_CLK(out_pclk), .CAPTURE_BUSY(busy));
   pix_source src (.clk(clk), .strobe(strobe), .colour(colour), .line_sync(ls),
      .frame_sync(fs));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A bounded wait for the regenerated clock; n counts the edges taken.
   task automatic wait_pclk(input logic lvl, output int n);
      n = 0;
      while (out_pclk !== lvl) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 60) begin
            miscompares++;
            end_sim;
         end
      end
   endtask

   task automatic s_reset;
      chk({12'h000, link}, 16'h0000);
      chk(out_colour, 16'h0000);
      chk({12'h000, out_ls, out_fs, out_pclk, busy}, 16'h0002);
   endtask

   // Three back-to-back words per multiplier; 8X needs a longer pixel period.
   task automatic s_mode(input int m);
      int n;
      int high;
      high = (mode_tab[m] == `MULT_8X) ? 5 : 3;
      @(posedge clk);
      #1;
      mult = mode_tab[m];
      repeat (8) @(posedge clk);
      #1;
      fork
         for (int i = 0; i < 3; i++) src.send(word_tab[i], sync_tab[i][0], sync_tab[i][1], high);
         for (int i = 0; i < 3; i++) begin
            wait_pclk(1'b0, n);
            chk(out_colour, word_tab[i]);
            chk({14'h0000, out_fs, out_ls}, {14'h0000, sync_tab[i]});
            chk({15'h0000, busy}, 16'h0000);
            wait_pclk(1'b1, n);
            chk(16'(n), 16'h0003);
         end
      join
      repeat (12) @(posedge clk);
   endtask

   // A restart with the strobe parked high must not invent a pixel word.
   task automatic s_restart;
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      s_reset;
      repeat (16) @(posedge clk);
      #1;
      chk(out_colour, 16'h0000);
      chk({15'h0000, out_pclk}, 16'h0001);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      mult = `MULT_6X;
      miscompares = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      s_reset;
      for (int m = 0; m < 3; m++) s_mode(m);
      s_restart;
      s_mode(1);
      end_sim;
   end
endmodule
